// ===== rtl/dvic_pkg.sv
// Package: register map, field layouts and reset values of the interrupt controller
package dvic_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int SRC_PER_UNIT = 32;
	localparam int VEC_PER_UNIT = 16;
	localparam int VEC_IDX_W = 4;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ****************************************
	// Register offsets (bytes)
	// ****************************************
	localparam logic [ADDR_W-1:0] OFF_ENABLE = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_FASTSEL = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_RAWSTAT = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_IRQSTAT = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_FASTSTAT = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_CURVEC = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_DEFVEC = 12'h018;
	localparam logic [ADDR_W-1:0] OFF_EVSTAT = 12'h01C;
	localparam logic [ADDR_W-1:0] OFF_EVMASK = 12'h020;
	localparam logic [ADDR_W-1:0] OFF_DONE = 12'h024;
	localparam logic [ADDR_W-1:0] OFF_VADDR = 12'h100;
	localparam logic [ADDR_W-1:0] OFF_VCTRL = 12'h140;
	// Unit stride: secondary unit sits above the primary
	localparam logic [ADDR_W-1:0] OFF_UNIT1 = 12'h800;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int VCTRL_EN_BIT = 5;
	localparam int CHAIN_SRC = 31;
	localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
	localparam int EV_FAST = 0;
	localparam int EV_IRQ = 1;
	localparam int EV_W = 2;
endpackage : dvic_pkg

// ===== rtl/dvic_vec_mem.sv
// Handler address memory of one vectored unit, registered read port
`timescale 1ns/1ns
module dvic_vec_mem #(
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter int DW = 32
) (
	input wire logic sys_clk,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrIdx,
	input wire logic [DW-1:0] wrData,
	input wire logic [AW-1:0] rdIdx,
	output logic [DW-1:0] rdData
);
	logic [DW-1:0] mem [DEPTH];

	// ****************************************
	// Storage
	// ****************************************
	// Write port and registered read
	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrIdx] <= wrData;
		end
		rdData <= mem[rdIdx];
	end
endmodule : dvic_vec_mem

// ===== rtl/dvic_unit.sv
// One vectored interrupt unit: classify, mask, prioritise, select handler
`timescale 1ns/1ns
module dvic_unit
	import dvic_pkg::*;
#(
	parameter int NSRC = 32,
	parameter int NVEC = 16
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [NSRC-1:0] reqIn,
	input wire logic [NSRC-1:0] enableMask,
	input wire logic [NSRC-1:0] fastSel,
	input wire logic [NVEC-1:0] vecEnable,
	input wire logic [NVEC*5-1:0] vecSrc,
	input wire logic vecWr,
	input wire logic [VEC_IDX_W-1:0] vecWrIdx,
	input wire logic [DATA_W-1:0] vecWrData,
	input wire logic [DATA_W-1:0] defaultVec,
	output logic [NSRC-1:0] irqStat,
	output logic [NSRC-1:0] fastStat,
	output logic fastOut,
	output logic irqOut,
	output logic vecHit,
	output logic [VEC_IDX_W-1:0] winIdx,
	output logic [DATA_W-1:0] handlerAddr
);
	logic [NVEC-1:0] slotActive;
	logic [VEC_IDX_W-1:0] winIdx_nxt;
	logic [DATA_W-1:0] memData;
	logic vecHit_r;

	// ****************************************
	// Classification and masking
	// ****************************************
	// Unlatched levels gated by the mask
	assign irqStat = reqIn & enableMask & ~fastSel;
	assign fastStat = reqIn & enableMask & fastSel;
	assign fastOut = |fastStat;
	assign irqOut = |irqStat;

	// Slot n fires when enabled and its source has a normal request
	always_comb begin
		for (int n = 0; n < NVEC; n++) begin
			slotActive[n] = vecEnable[n] & irqStat[vecSrc[n*5 +: 5]];
		end
	end

	// Lowest slot number wins
	always_comb begin
		winIdx_nxt = '0;
		for (int n = NVEC - 1; n >= 0; n--) begin
			if (slotActive[n]) begin
				winIdx_nxt = VEC_IDX_W'(n);
			end
		end
	end

	// Winner captured alongside the memory read
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			winIdx <= '0;
			vecHit_r <= 1'b0;
		end else begin
			winIdx <= winIdx_nxt;
			vecHit_r <= |slotActive;
		end
	end

	dvic_vec_mem #(.DEPTH(NVEC), .AW(VEC_IDX_W), .DW(DATA_W)) u_mem (
		.sys_clk(sys_clk),
		.wrEn(vecWr),
		.wrIdx(vecWrIdx),
		.wrData(vecWrData),
		.rdIdx(winIdx_nxt),
		.rdData(memData)
	);

	// Default vector when no slot hits
	assign vecHit = vecHit_r;
	assign handlerAddr = vecHit_r ? memData : defaultVec;
endmodule : dvic_unit

// ===== rtl/dual_vectored_irq_ctrl.sv
// Top: two chained vectored interrupt units behind an APB slave
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ns
module dual_vectored_irq_ctrl
	import dvic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [63:0] reqPin,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dvic_pkg::ADDR_W-1:0] paddr,
	input wire logic [dvic_pkg::DATA_W-1:0] pwdata,
	output logic [dvic_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic fastIrqLine,
	output logic normalIrqLine,
	output logic wakeReq,
	output logic [dvic_pkg::DATA_W-1:0] handlerAddr,
	output logic eventIrq
);
	// ****************************************
	// Declarations
	// ****************************************
	logic [63:0] reqMeta_r;
	logic [63:0] reqSync_r;
	logic [SRC_PER_UNIT-1:0] enable_r [2];
	logic [SRC_PER_UNIT-1:0] fastSel_r [2];
	logic [VEC_PER_UNIT-1:0] vecEn_r [2];
	logic [VEC_PER_UNIT*5-1:0] vecSrc_r [2];
	logic [DATA_W-1:0] defVec_r [2];
	logic [EV_W-1:0] evStat_r;
	logic [EV_W-1:0] evMask_r;
	logic [EV_W-1:0] evStat_nxt;
	logic fastPrev_r;
	logic irqPrev_r;
	logic [DATA_W-1:0] prdata_r;
	logic [SRC_PER_UNIT-1:0] unitReq [2];
	logic [SRC_PER_UNIT-1:0] irqStat [2];
	logic [SRC_PER_UNIT-1:0] fastStat [2];
	logic [DATA_W-1:0] unitAddr [2];
	logic [VEC_IDX_W-1:0] unitWin [2];
	logic unitFast [2];
	logic unitIrq [2];
	logic unitHit [2];
	logic unitVecWr [2];
	logic [DATA_W-1:0] rdMux;
	logic chainReq;

	// ****************************************
	// Bus decode
	// ****************************************
	// Write strobe in the access phase, read strobe in the setup phase; unit split
	wire wrStb = psel & penable & pwrite;
	// Read data is captured in the setup cycle so it stands at the access edge
	wire rdStb = psel & ~penable & ~pwrite;
	wire unitSel = paddr[11];
	wire [ADDR_W-1:0] off = {1'b0, paddr[10:0]};
	wire isVaddr = (off >= OFF_VADDR) && (off < OFF_VADDR + 12'h040);
	wire isVctrl = (off >= OFF_VCTRL) && (off < OFF_VCTRL + 12'h040);
	wire [VEC_IDX_W-1:0] slotIdx = off[5:2];
	wire isKnown = isVaddr | isVctrl | (off <= OFF_DONE);
	wire misAlign = |paddr[1:0];

	// Single-wait-free slave; bad offsets raise an error
	assign pready = 1'b1;
	assign pslverr = psel & penable & (~isKnown | misAlign);
	assign prdata = prdata_r;

	// ****************************************
	// Request input synchroniser
	// ****************************************
	// Two flops on every pin; no storage beyond that
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reqMeta_r <= '0;
			reqSync_r <= '0;
		end else begin
			reqMeta_r <= reqPin;
			reqSync_r <= reqMeta_r;
		end
	end

	// ****************************************
	// Chaining of the two units
	// ****************************************
	// Secondary's combined normal request enters the primary's top source
	assign chainReq = unitIrq[1] | unitHit[1];
	assign unitReq[1] = reqSync_r[63:32];
	assign unitReq[0] = {chainReq | reqSync_r[CHAIN_SRC], reqSync_r[30:0]};

	// Per-unit vector memory write strobes
	assign unitVecWr[0] = wrStb & ~unitSel & isVaddr & ~misAlign;
	assign unitVecWr[1] = wrStb & unitSel & isVaddr & ~misAlign;

	for (genvar u = 0; u < 2; u++) begin : g_unit
		dvic_unit #(.NSRC(SRC_PER_UNIT), .NVEC(VEC_PER_UNIT)) u_unit (
			.sys_clk(sys_clk),
			.reset(reset),
			.reqIn(unitReq[u]),
			.enableMask(enable_r[u]),
			.fastSel(fastSel_r[u]),
			.vecEnable(vecEn_r[u]),
			.vecSrc(vecSrc_r[u]),
			.vecWr(unitVecWr[u]),
			.vecWrIdx(slotIdx),
			.vecWrData(pwdata),
			.defaultVec(defVec_r[u]),
			.irqStat(irqStat[u]),
			.fastStat(fastStat[u]),
			.fastOut(unitFast[u]),
			.irqOut(unitIrq[u]),
			.vecHit(unitHit[u]),
			.winIdx(unitWin[u]),
			.handlerAddr(unitAddr[u])
		);
	end

	// ****************************************
	// Processor lines
	// ****************************************
	// Fast from either unit; normal only via the primary
	assign fastIrqLine = unitFast[0] | unitFast[1];
	assign normalIrqLine = unitIrq[0] & ~fastIrqLine;
	// Combinational so it acts with the core clock stopped
	assign wakeReq = fastIrqLine | unitIrq[0];
	// Primary slot win, else its default (which covers chained sources)
	assign handlerAddr = unitAddr[0];

	// ****************************************
	// Configuration registers
	// ****************************************
	// Masks cleared on reset, written per unit
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int u = 0; u < 2; u++) begin
				enable_r[u] <= RST_ZERO;
				fastSel_r[u] <= RST_ZERO;
				defVec_r[u] <= RST_ZERO;
			end
		end else if (wrStb & ~misAlign) begin
			if (off == OFF_ENABLE) begin
				enable_r[unitSel] <= pwdata;
			end
			if (off == OFF_FASTSEL) begin
				fastSel_r[unitSel] <= pwdata;
			end
			if (off == OFF_DEFVEC) begin
				defVec_r[unitSel] <= pwdata;
			end
		end
	end

	// Slot control: source number and enable bit
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			vecEn_r[0] <= '0;
			vecEn_r[1] <= '0;
			vecSrc_r[0] <= '0;
			vecSrc_r[1] <= '0;
		end else if (wrStb & isVctrl & ~misAlign) begin
			vecEn_r[unitSel][slotIdx] <= pwdata[VCTRL_EN_BIT];
			vecSrc_r[unitSel][slotIdx*5 +: 5] <= pwdata[4:0];
		end
	end

	// ****************************************
	// Event status and interrupt
	// ****************************************
	// Rising processor lines set sticky bits; set wins over clear
	assign evStat_nxt[EV_FAST] = (fastIrqLine & ~fastPrev_r) |
		(evStat_r[EV_FAST] & ~(wrStb & off == OFF_EVSTAT & ~unitSel & pwdata[EV_FAST]));
	assign evStat_nxt[EV_IRQ] = (normalIrqLine & ~irqPrev_r) |
		(evStat_r[EV_IRQ] & ~(wrStb & off == OFF_EVSTAT & ~unitSel & pwdata[EV_IRQ]));

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			evStat_r <= '0;
			evMask_r <= '0;
			fastPrev_r <= 1'b0;
			irqPrev_r <= 1'b0;
		end else begin
			evStat_r <= evStat_nxt;
			fastPrev_r <= fastIrqLine;
			irqPrev_r <= normalIrqLine;
			if (wrStb & ~unitSel & off == OFF_EVMASK) begin
				evMask_r <= pwdata[EV_W-1:0];
			end
		end
	end

	assign eventIrq = |(evStat_r & evMask_r);

	// ****************************************
	// Read path
	// ****************************************
	// Raw, normal and fast status words expose live levels for software ordering; event status is sticky
	always_comb begin
		rdMux = '0;
		if (isVaddr) begin
			rdMux = '0;
		end else if (isVctrl) begin
			rdMux = {26'h0, vecEn_r[unitSel][slotIdx], vecSrc_r[unitSel][slotIdx*5 +: 5]};
		end else begin
			unique case (off)
				OFF_ENABLE: rdMux = enable_r[unitSel];
				OFF_FASTSEL: rdMux = fastSel_r[unitSel];
				OFF_RAWSTAT: rdMux = unitReq[unitSel];
				OFF_IRQSTAT: rdMux = irqStat[unitSel];
				OFF_FASTSTAT: rdMux = fastStat[unitSel];
				OFF_CURVEC: rdMux = unitAddr[unitSel];
				OFF_DEFVEC: rdMux = defVec_r[unitSel];
				OFF_EVSTAT: rdMux = {30'h0, evStat_r};
				OFF_EVMASK: rdMux = {30'h0, evMask_r};
				OFF_DONE: rdMux = {28'h0, unitWin[unitSel]};
				default: rdMux = '0;
			endcase
		end
	end

	// Read data registered at the setup edge, held through the access phase
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prdata_r <= RST_ZERO;
		end else if (rdStb) begin
			prdata_r <= rdMux;
		end
	end
endmodule : dual_vectored_irq_ctrl

// ===== tb/dvic_checker.sv
// Checker: port-level properties of the interrupt controller
`timescale 1ns/1ns
module dvic_checker (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [63:0] reqPin,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic fastIrqLine,
	input wire logic normalIrqLine,
	input wire logic wakeReq,
	input wire logic eventIrq
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence accS;
		psel && penable;
	endsequence
	sequence quietS;
		(reqPin == 64'h0)[*3];
	endsequence
	reset_clear_a: assert property ($fell(reset) |-> !fastIrqLine && !normalIrqLine)
		else $error("line set after reset");
	fast_first_a: assert property (fastIrqLine |-> !normalIrqLine)
		else $error("both lines high");
	wake_follow_a: assert property (wakeReq == (fastIrqLine || normalIrqLine))
		else $error("wake not following lines");
	no_latch_a: assert property (quietS |-> !fastIrqLine && !normalIrqLine && !wakeReq)
		else $error("line held without request");
	zero_wait_a: assert property (accS |-> pready)
		else $error("access not answered");
	misalign_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned not refused");
	unmapped_err_a: assert property (psel && penable && paddr == 12'h030 |-> pslverr)
		else $error("unmapped not refused");
	idle_noerr_a: assert property (!(psel && penable) |-> !pslverr)
		else $error("error outside access");
endmodule : dvic_checker

bind dual_vectored_irq_ctrl dvic_checker u_dvic_checker (.sys_clk(sys_clk), .reset(reset),
	.reqPin(reqPin), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .fastIrqLine(fastIrqLine), .normalIrqLine(normalIrqLine),
	.wakeReq(wakeReq), .eventIrq(eventIrq));

// ===== tb/dvic_core_model.sv
// Processor core model: notes taken fast and normal interrupts
`timescale 1ns/1ns
module dvic_core_model (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic fastIn,
	input wire logic normalIn,
	output logic fastSeen,
	output logic irqSeen
);
	// Core takes fast first; a normal interrupt is noted only while fast is low
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			fastSeen <= 1'b0;
			irqSeen <= 1'b0;
		end else begin
			fastSeen <= fastSeen | fastIn;
			irqSeen <= irqSeen | (normalIn & ~fastIn);
		end
	end
endmodule : dvic_core_model

// ===== tb/dual_vectored_irq_ctrl_tb.sv
// Testbench of the chained interrupt controller
`timescale 1ns/1ns
module dual_vectored_irq_ctrl_tb;
	import dvic_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [63:0] reqPin = 64'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, handlerAddr, rd, em, fs;
	logic pready, pslverr, fastIrqLine, normalIrqLine, wakeReq, eventIrq, er, fSeen, nSeen;
	logic [31:0] pat [5] = '{32'h08, 32'h28, 32'h40, 32'h88, 32'h01};
	logic [31:0] hv [5] = '{32'hB000_0000, 32'hA000_0000, 32'hD0D0_0000, 32'hB000_0000,
		32'hD0D0_0000};
	logic [1:0] lv [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h0};
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int i;

	dual_vectored_irq_ctrl u_dual_vectored_irq_ctrl (.sys_clk(sys_clk), .reset(reset),
		.reqPin(reqPin), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fastIrqLine(fastIrqLine), .normalIrqLine(normalIrqLine), .wakeReq(wakeReq),
		.handlerAddr(handlerAddr), .eventIrq(eventIrq));
	dvic_core_model u_dvic_core_model (.sys_clk(sys_clk), .reset(reset),
		.fastIn(fastIrqLine), .normalIn(normalIrqLine), .fastSeen(fSeen), .irqSeen(nSeen));

	// ****
	// Helpers
	// ****
	initial forever #5 sys_clk = ~sys_clk;
	// Hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("err_count=%0d tests_run=%0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; response and read data taken at the access edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		er = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	function automatic logic [1:0] expLines(logic [31:0] r, logic [31:0] e, logic [31:0] f);
		return {|(r & e & f), ~|(r & e & f) & |(r & e & ~f)};
	endfunction : expLines

	// ****
	// Sequence
	// ****
	initial begin
		void'($urandom(91809));
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		bus(1'b0, OFF_ENABLE, 32'h0);
		chk(rd, RST_ZERO);
		reqPin <= {$urandom, $urandom};
		repeat (4) @(posedge sys_clk);
		chk({fastIrqLine, normalIrqLine}, 32'h0);
		for (i = 0; i < 16; i++) begin
			em = $urandom;
			fs = $urandom;
			bus(1'b1, OFF_ENABLE, em);
			bus(1'b1, OFF_FASTSEL, fs);
			reqPin <= {32'h0, (i == 0) ? 32'hFFFF_FFFF : $urandom};
			repeat (4) @(posedge sys_clk);
			chk({fastIrqLine, normalIrqLine}, expLines(reqPin[31:0], em, fs));
		end
		bus(1'b1, OFF_FASTSEL, 32'h80);
		bus(1'b1, OFF_ENABLE, 32'hE8);
		bus(1'b1, OFF_DEFVEC, 32'hD0D0_0000);
		bus(1'b1, OFF_VADDR, 32'hA000_0000);
		bus(1'b1, OFF_VADDR + 12'h004, 32'hB000_0000);
		bus(1'b1, OFF_VCTRL, 32'h25);
		bus(1'b1, OFF_VCTRL + 12'h004, 32'h23);
		for (i = 0; i < 5; i++) begin
			reqPin <= {32'h0, pat[i]};
			repeat (4) @(posedge sys_clk);
			chk(handlerAddr, hv[i]);
			chk({fastIrqLine, normalIrqLine}, lv[i]);
		end
		chk({fSeen, nSeen}, 32'h3);
		bus(1'b1, OFF_UNIT1 + OFF_ENABLE, 32'h4);
		bus(1'b1, OFF_ENABLE, 32'h8000_0000);
		bus(1'b1, OFF_EVSTAT, 32'h3);
		bus(1'b1, OFF_EVMASK, 32'h2);
		reqPin <= 64'h0000_0004_0000_0000;
		repeat (4) @(posedge sys_clk);
		chk({fastIrqLine, normalIrqLine, eventIrq}, 32'h3);
		chk(handlerAddr, 32'hD0D0_0000);
		bus(1'b1, OFF_EVMASK, 32'h0);
		chk(eventIrq, 32'h0);
		bus(1'b0, OFF_EVSTAT, 32'h0);
		chk(rd, 32'h2);
		bus(1'b1, OFF_EVSTAT, 32'h2);
		bus(1'b1, OFF_EVMASK, 32'h2);
		chk(eventIrq, 32'h0);
		bus(1'b0, 12'h030, 32'h0);
		chk(er, 32'h1);
		chk(rd, 32'h0);
		bus(1'b1, OFF_ENABLE + 12'h001, 32'h0);
		chk(er, 32'h1);
		finish_test();
	end
endmodule : dual_vectored_irq_ctrl_tb
